// >>> logic/cbw_pkg.sv
// constants for the card-bus I/O window and bridge control block
// assumes an 8-bit configuration offset with register data in the low bits
package cbw_pkg;
  // register offsets
  localparam logic [7:0] OFS_IO0_BASE = 8'h2C;
  localparam logic [7:0] OFS_IO0_LIM  = 8'h30;
  localparam logic [7:0] OFS_IO1_BASE = 8'h34;
  localparam logic [7:0] OFS_IO1_LIM  = 8'h38;
  localparam logic [7:0] OFS_IRQ_LINE = 8'h3C;
  localparam logic [7:0] OFS_IRQ_PIN  = 8'h3D;
  localparam logic [7:0] OFS_BCTL     = 8'h3E;
  localparam logic [7:0] OFS_DEV_CTL  = 8'h92;
  // writable bits and reset values
  localparam logic [31:0] IO_BASE_WMASK = 32'hFFFF_FFFC;
  localparam logic [15:0] IO_LIM_WMASK  = 16'hFFFC;
  localparam logic [15:0] BCTL_WMASK    = 16'h07EF;
  localparam logic [31:0] IO_BASE_RST   = 32'h0000_0000;
  localparam logic [15:0] IO_LIM_RST    = 16'h0000;
  localparam logic [7:0]  IRQ_LINE_RST  = 8'hFF;
  localparam logic [15:0] BCTL_RST      = 16'h0340;
  // interrupt signalling select: 00 parallel, other codes serialized
  localparam logic [1:0]  MODE_PARALLEL = 2'h0;
  localparam logic [1:0]  MODE_RST      = 2'h2;
  localparam logic [7:0]  IRQ_PIN_NONE  = 8'h00;
  localparam logic [7:0]  IRQ_PIN_INTA  = 8'h01;
  // field positions
  localparam int DEV_MODE_LSB  = 1;
  localparam int DEV_CPERR_BIT = 8;
  localparam int BC_WRITE_POSTING_ENABLE     = 10;
  localparam int BC_PREF1      = 9;
  localparam int BC_PREF0      = 8;
  localparam int BC_FUNC_IRQ_ROUTE_SELECT       = 7;
  localparam int BC_CRST       = 6;
  localparam int BC_MABT       = 5;
  localparam int BC_VGA        = 3;
  localparam int BC_ISA        = 2;
  localparam int BC_CSERR      = 1;
  localparam int BC_CPERR      = 0;
  // legacy address ranges
  localparam logic [31:0] VGA_MONO_LO  = 32'h0000_03B0;
  localparam logic [31:0] VGA_MONO_HI  = 32'h0000_03BB;
  localparam logic [31:0] VGA_COLOR_LO = 32'h0000_03C0;
  localparam logic [31:0] VGA_COLOR_HI = 32'h0000_03DF;
  localparam logic [15:0] ISA_PAGE     = 16'h0000;
  localparam logic [1:0]  DW_ONES      = 2'h3;
  // card parity error drive sequence
  typedef enum logic [1:0] {
    PE_IDLE    = 2'h0,
    PE_DRIVE   = 2'h1,
    PE_RELEASE = 2'h3
  } cbw_perr_t;
endpackage

// >>> logic/cbw_pin_sync.sv
// two-flop synchroniser with edge detection for card-side pins
// assumes inputs asynchronous to clk; outputs are clk-domain levels and pulses
`timescale 1ns/1ns
module cbw_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // raw pins and synchronised view
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } cbw_sync_t;

  cbw_sync_t q;
  cbw_sync_t d;

  // shift chain; s1 feeds only s2
  always_comb begin
    d    = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  // reset to the idle-high pin level so no false edge or low follows reset
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign level = q.s2;
  assign rise  = q.s2 & ~q.s3;
endmodule

// >>> logic/cbw_bridge_ctrl.sv
// I/O window decode, interrupt registers and bridge control of a card-bus bridge
// assumes one-cycle config strobes on clk and card pins arriving asynchronously
`timescale 1ns/1ns
module cbw_bridge_ctrl
  import cbw_pkg::*;
(
  // clock and synchronous reset
  input  wire logic        clk,
  input  wire logic        srst,
  // configuration register port
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  output logic      [31:0] cfg_rdata,
  // I/O cycle decode
  input  wire logic        io_req,
  input  wire logic        io_from_card,
  input  wire logic [31:0] io_addr,
  output logic             io_claim,
  output logic             io_to_pci,
  // error events and responses
  input  wire logic        card_master_abort,
  input  wire logic        card_parity_err,
  input  wire logic        serr_enable,
  output logic             target_abort,
  output logic             serr_pulse,
  // card link pins
  input  wire logic        card_clk,
  input  wire logic        cserr_n,
  input  wire logic        cperr_n_i,
  output logic             cperr_n_o,
  output logic             cperr_oe,
  output logic             card_rst_n,
  // control levels
  output logic             write_posting_enable,
  output logic             mem_window1_prefetchable,
  output logic             mem_window0_prefetchable,
  output logic             func_irq_route_select,
  output logic [1:0]       irq_signalling_select
);
  import cbw_pkg::*;

  typedef struct packed {
    logic [1:0][31:0] base;
    logic [1:0][15:0] lim;
    logic [7:0]       irq_line;
    logic [15:0]      bctl;
    logic [1:0]       mode;
    logic [31:0]      rdata;
    logic             claim;
    logic             up;
    logic             tabort;
    logic             serr;
    logic             crst_n;
    cbw_perr_t        perr;
    logic             pdrive;
    logic             poe;
  } cbw_state_t;

  cbw_state_t q;
  cbw_state_t d;

  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;

  // card clock, system error and parity pins enter through the synchroniser
  cbw_pin_sync #(
    .W (3)
  ) u_sync (
    .clk   (clk),
    .srst  (srst),
    .pin   ({cperr_n_i, cserr_n, card_clk}),
    .level (pin_lvl),
    .rise  (pin_rise)
  );

  // window hit: enabled, page match, offset between bottom and top inclusive
  function automatic logic win_hit(input logic [31:0] base,
                                   input logic [15:0] lim,
                                   input logic [31:0] addr);
    logic enabled;
    logic [15:0] top;
    enabled = (base != '0) || (lim != '0);
    top     = {lim[15:2], DW_ONES};
    win_hit = enabled && (addr[31:16] == base[31:16])
              && (addr[15:0] >= base[15:0])
              && (addr[15:0] <= top);
  endfunction

  // address inside one of the legacy VGA I/O ranges
  function automatic logic vga_hit(input logic [31:0] addr);
    vga_hit = ((addr >= VGA_MONO_LO) && (addr <= VGA_MONO_HI))
              || ((addr >= VGA_COLOR_LO) && (addr <= VGA_COLOR_HI));
  endfunction

  logic any_win;
  logic isa_block;
  logic vga_fwd;
  logic cserr_evt;
  logic mabt_rpt;

  // decode terms shared by the next-state logic and the assertions
  always_comb begin
    any_win   = win_hit(q.base[0], q.lim[0], io_addr)
                || win_hit(q.base[1], q.lim[1], io_addr);
    isa_block = q.bctl[BC_ISA] && (io_addr[31:16] == ISA_PAGE)
                && (io_addr[9:8] != 2'h0);
    vga_fwd   = q.bctl[BC_VGA] && vga_hit(io_addr);
    cserr_evt = pin_rise[0] && !pin_lvl[1];
    mabt_rpt  = card_master_abort && q.bctl[BC_MABT];
  end

  // next state: register writes, read mux, decode and error responses
  always_comb begin
    d = q;
    // register writes; bits outside the write mask are cleared
    if (cfg_wr) begin
      case (cfg_addr)
        OFS_IO0_BASE: d.base[0] = cfg_wdata & IO_BASE_WMASK;
        OFS_IO1_BASE: d.base[1] = cfg_wdata & IO_BASE_WMASK;
        OFS_IO0_LIM:  d.lim[0]  = cfg_wdata[15:0] & IO_LIM_WMASK;
        OFS_IO1_LIM:  d.lim[1]  = cfg_wdata[15:0] & IO_LIM_WMASK;
        OFS_IRQ_LINE: d.irq_line = cfg_wdata[7:0];
        OFS_BCTL:     d.bctl = cfg_wdata[15:0] & BCTL_WMASK;
        OFS_DEV_CTL:  d.mode = cfg_wdata[DEV_MODE_LSB +: 2];
        default: begin
        end
      endcase
    end
    // read data stand one cycle, zero otherwise
    d.rdata = '0;
    if (cfg_rd) begin
      case (cfg_addr)
        OFS_IO0_BASE: d.rdata = q.base[0];
        OFS_IO1_BASE: d.rdata = q.base[1];
        OFS_IO0_LIM:  d.rdata = {16'h0000, q.lim[0]};
        OFS_IO1_LIM:  d.rdata = {16'h0000, q.lim[1]};
        OFS_IRQ_LINE: d.rdata = {24'h000000, q.irq_line};
        OFS_IRQ_PIN: begin
          // pin code follows the signalling select
          d.rdata[7:0] = (q.mode == MODE_PARALLEL) ? IRQ_PIN_NONE
                                                   : IRQ_PIN_INTA;
        end
        OFS_BCTL:     d.rdata = {16'h0000, q.bctl};
        OFS_DEV_CTL: begin
          d.rdata[DEV_MODE_LSB +: 2] = q.mode;
          d.rdata[DEV_CPERR_BIT]     = !pin_lvl[2];
        end
        default: d.rdata = '0;
      endcase
    end
    // I/O claim downstream and upstream pass-through
    d.claim = io_req && !io_from_card
              && ((any_win && !isa_block) || vga_fwd);
    d.up    = io_req && io_from_card && !any_win;
    // abort and system error reporting
    d.tabort = mabt_rpt;
    d.serr   = (mabt_rpt && serr_enable)
               || (cserr_evt && q.bctl[BC_CSERR]);
    // card reset follows the control bit; bus reset handled below
    d.crst_n = !q.bctl[BC_CRST];
    // parity report: drive low until the next card clock rise, then high one card clock, then release
    case (q.perr)
      PE_IDLE: begin
        if (card_parity_err && q.bctl[BC_CPERR]) begin
          d.perr   = PE_DRIVE;
          d.pdrive = 1'b0;
          d.poe    = 1'b1;
        end
      end
      PE_DRIVE: begin
        if (pin_rise[0]) begin
          d.perr   = PE_RELEASE;
          d.pdrive = 1'b1;
        end
      end
      PE_RELEASE: begin
        if (pin_rise[0]) begin
          d.perr = PE_IDLE;
          d.poe  = 1'b0;
        end
      end
      default: begin
        d.perr = PE_IDLE;
        d.poe  = 1'b0;
      end
    endcase
  end

  // state register; bus reset also asserts card reset
  always_ff @(posedge clk) begin
    if (srst) begin
      q          <= '0;
      q.base     <= {IO_BASE_RST, IO_BASE_RST};
      q.lim      <= {IO_LIM_RST, IO_LIM_RST};
      q.irq_line <= IRQ_LINE_RST;
      q.bctl     <= BCTL_RST;
      q.mode     <= MODE_RST;
      q.crst_n   <= 1'b0;
      q.perr     <= PE_IDLE;
      q.pdrive   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign cfg_rdata                = q.rdata;
  assign io_claim                 = q.claim;
  assign io_to_pci                = q.up;
  assign target_abort             = q.tabort;
  assign serr_pulse               = q.serr;
  assign card_rst_n               = q.crst_n;
  assign cperr_n_o                = q.pdrive;
  assign cperr_oe                 = q.poe;
  assign write_posting_enable     = q.bctl[BC_WRITE_POSTING_ENABLE];
  assign mem_window1_prefetchable = q.bctl[BC_PREF1];
  assign mem_window0_prefetchable = q.bctl[BC_PREF0];
  assign func_irq_route_select    = q.bctl[BC_FUNC_IRQ_ROUTE_SELECT];
  assign irq_signalling_select    = q.mode;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_base_wr_rd: assert property (
    (cfg_wr && cfg_addr == OFS_IO0_BASE) ##1 (cfg_rd && !cfg_wr && cfg_addr == OFS_IO0_BASE)
    |=> cfg_rdata == ($past(cfg_wdata, 2) & IO_BASE_WMASK))
    else $error("window base readback wrong");

  a_lim_upper_zero: assert property (
    cfg_rd && (cfg_addr == OFS_IO0_LIM || cfg_addr == OFS_IO1_LIM)
    |=> cfg_rdata[31:16] == 16'h0000 && cfg_rdata[1:0] == 2'h0)
    else $error("limit read-only bits not zero");

  a_window_off: assert property (
    io_req && !io_from_card && q.base == '0 && q.lim == '0 && !q.bctl[BC_VGA]
    |=> !io_claim)
    else $error("claim with windows disabled");

  a_limit_top: assert property (
    io_req && !io_from_card && q.base[1] != '0 && !q.bctl[BC_ISA]
    && io_addr[31:16] == q.base[1][31:16] && io_addr[15:0] == {q.lim[1][15:2], DW_ONES}
    && q.lim[1] >= q.base[1][15:0]
    |=> io_claim)
    else $error("window top not claimed");

  a_isa_filter: assert property (
    io_req && !io_from_card && q.bctl[BC_ISA] && io_addr[31:16] == ISA_PAGE
    && io_addr[9:8] != 2'h0 && !vga_fwd
    |=> !io_claim)
    else $error("isa upper range forwarded");

  a_card_reset: assert property (
    q.bctl[BC_CRST] ##1 q.bctl[BC_CRST] |-> !card_rst_n)
    else $error("card reset not asserted");

  a_mabt_quiet: assert property (
    card_master_abort && !q.bctl[BC_MABT] |=> !target_abort)
    else $error("master abort reported while off");

  a_perr_drive: assert property (
    q.perr == PE_IDLE && card_parity_err && q.bctl[BC_CPERR]
    |=> cperr_oe && !cperr_n_o ##1 cperr_oe)
    else $error("parity error not driven");

  a_pin_code: assert property (
    cfg_rd && cfg_addr == OFS_IRQ_PIN
    |=> cfg_rdata[7:0] == (($past(q.mode) == MODE_PARALLEL) ? IRQ_PIN_NONE : IRQ_PIN_INTA))
    else $error("interrupt pin code wrong");

  a_bctl_rsvd: assert property (
    cfg_rd && cfg_addr == OFS_BCTL |=> cfg_rdata[15:11] == 5'h00 && !cfg_rdata[4])
    else $error("reserved control bits set");

  a_io_idle: assert property (
    !io_req |=> !io_claim && !io_to_pci)
    else $error("decode pulse without request");

  a_card_not_claimed: assert property (
    io_req && io_from_card |=> !io_claim)
    else $error("card cycle claimed downstream");

  a_base_low_zero: assert property (
    cfg_rd && (cfg_addr == OFS_IO0_BASE || cfg_addr == OFS_IO1_BASE)
    |=> cfg_rdata[1:0] == 2'h0)
    else $error("base low bits not zero");

  a_line_width: assert property (
    cfg_rd && cfg_addr == OFS_IRQ_LINE |=> cfg_rdata[31:8] == 24'h000000)
    else $error("interrupt line upper bits set");

  a_posting_bit: assert property (
    cfg_wr && cfg_addr == OFS_BCTL && cfg_wdata[BC_WRITE_POSTING_ENABLE]
    |=> write_posting_enable)
    else $error("posting enable not written");

  a_prefetch_clr: assert property (
    cfg_wr && cfg_addr == OFS_BCTL && !cfg_wdata[BC_PREF0]
    |=> !mem_window0_prefetchable)
    else $error("window 0 still prefetchable");

  a_crst_release: assert property (
    !q.bctl[BC_CRST] ##1 !q.bctl[BC_CRST] |-> card_rst_n)
    else $error("card reset held while bit clear");

  a_mabt_report: assert property (
    card_master_abort && q.bctl[BC_MABT] |=> target_abort)
    else $error("master abort not reported");

  a_mabt_serr: assert property (
    card_master_abort && q.bctl[BC_MABT] && serr_enable
    |=> serr_pulse)
    else $error("master abort system error missing");

  a_perr_quiet: assert property (
    q.perr == PE_IDLE && !(card_parity_err && q.bctl[BC_CPERR]) |=> !cperr_oe)
    else $error("parity pin driven without error");

  a_cserr_off: assert property (
    cserr_evt && !q.bctl[BC_CSERR] && !(mabt_rpt && serr_enable)
    |=> !serr_pulse)
    else $error("card system error forwarded while off");

  c_claim: cover property (io_req && !io_from_card ##1 io_claim);
  c_upstream: cover property (io_req && io_from_card ##1 io_to_pci);
  c_perr_seq: cover property (q.perr == PE_DRIVE ##[1:40] q.perr == PE_RELEASE);
  c_serr: cover property (serr_pulse);
endmodule

// >>> sim/cbw_card_model.sv
// card-side partner: free-running card clock, system error pin, parity pin
// assumes the bench commands card system errors through serr_req
`timescale 1ns/1ns
module cbw_card_model (
  // bench command
  input  wire logic serr_req,
  // parity pin as driven by the bridge
  input  wire logic cperr_n_o,
  input  wire logic cperr_oe,
  // card pins seen by the bridge
  output logic      card_clk,
  output logic      cserr_n,
  output logic      cperr_n_i
);
  // card clock, 48 ns period, phase unrelated to clk
  initial begin
    card_clk = 1'b0;
    #7;
    forever #24 card_clk = ~card_clk;
  end
  // system error changes on the falling card clock, away from rises
  initial cserr_n = 1'b1;
  always @(negedge card_clk) cserr_n <= ~serr_req;
  // pull-up holds the parity pin high once the bridge releases it
  assign cperr_n_i = cperr_oe ? cperr_n_o : 1'b1;
endmodule

// >>> sim/cbw_bridge_ctrl_tb.sv
// self-checking bench for the I/O window and bridge control block
// assumes the card model supplies the card clock and card pins
`timescale 1ns/1ns
module cbw_bridge_ctrl_tb;
  import cbw_pkg::*;
  logic        clk, srst, cfg_wr, cfg_rd, io_req, io_from_card, serr_req;
  logic        card_master_abort, card_parity_err, serr_enable;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, io_addr;
  logic        io_claim, io_to_pci, target_abort, serr_pulse, card_clk, cserr_n;
  logic        cperr_n_i, cperr_n_o, cperr_oe, card_rst_n, posting, pref1, pref0, route;
  logic [1:0]  irq_sel;
  int          error_cnt, compares, cyc, n;

  cbw_bridge_ctrl i_cbw_bridge_ctrl (.clk(clk), .srst(srst), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .io_req(io_req), .io_from_card(io_from_card), .io_addr(io_addr), .io_claim(io_claim),
    .io_to_pci(io_to_pci), .card_master_abort(card_master_abort),
    .card_parity_err(card_parity_err), .serr_enable(serr_enable),
    .target_abort(target_abort), .serr_pulse(serr_pulse), .card_clk(card_clk),
    .cserr_n(cserr_n), .cperr_n_i(cperr_n_i), .cperr_n_o(cperr_n_o), .cperr_oe(cperr_oe),
    .card_rst_n(card_rst_n), .write_posting_enable(posting),
    .mem_window1_prefetchable(pref1), .mem_window0_prefetchable(pref0),
    .func_irq_route_select(route), .irq_signalling_select(irq_sel));

  cbw_card_model i_cbw_card_model (.serr_req(serr_req), .cperr_n_o(cperr_n_o),
    .cperr_oe(cperr_oe), .card_clk(card_clk), .cserr_n(cserr_n), .cperr_n_i(cperr_n_i));

  // clock
  always #2 clk = ~clk;

  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // register write, one strobe cycle then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_wr    <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // write followed by a read of the same offset with no gap
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_wr    <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, cfg_rdata);
    @(posedge clk);
  endtask

  // register read, data checked in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, cfg_rdata);
    @(posedge clk);
  endtask

  // one I/O cycle, outcome checked one cycle later
  task automatic io(input logic [31:0] a, input logic fc, input logic ec, input logic ep);
    io_addr      <= a;
    io_from_card <= fc;
    io_req       <= 1'b1;
    @(posedge clk);
    io_req <= 1'b0;
    #1 chk($sformatf("claim %h", a), ec, io_claim);
    chk($sformatf("to_pci %h", a), ep, io_to_pci);
    @(posedge clk);
  endtask

  task automatic abort(input logic et, input logic es);
    card_master_abort <= 1'b1;
    @(posedge clk);
    card_master_abort <= 1'b0;
    #1 chk("target_abort", et, target_abort);
    chk("serr_pulse", es, serr_pulse);
    @(posedge clk);
  endtask

  task automatic t_reset;
    rd(OFS_IRQ_LINE, 32'h0000_00FF);
    rd(OFS_IRQ_PIN, 32'h0000_0001);
    rd(OFS_BCTL, 32'h0000_0340);
    rd(OFS_IO0_BASE, 32'h0000_0000);
    rd(OFS_IO1_LIM, 32'h0000_0000);
    chk("irq_sel", 2'h2, irq_sel);
    chk("card_rst_n", 1'b0, card_rst_n);
    chk("pref", 2'h3, {pref1, pref0});
    chk("route", 1'b0, route);
  endtask

  task automatic t_masks;
    wr_rd(OFS_IO0_BASE, 32'hFFFF_FFFF, 32'hFFFF_FFFC);
    wr(OFS_IO0_LIM, 32'hFFFF_FFFF);
    rd(OFS_IO0_LIM, 32'h0000_FFFC);
    wr(OFS_IRQ_LINE, 32'h0000_005A);
    rd(OFS_IRQ_LINE, 32'h0000_005A);
    wr(OFS_IRQ_PIN, 32'h0000_0000);
    rd(OFS_IRQ_PIN, 32'h0000_0001);
    wr(OFS_BCTL, 32'h0000_FFFF);
    rd(OFS_BCTL, 32'h0000_07EF);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    wr(OFS_IO0_BASE, 32'h0000_0000);
    wr(OFS_IO0_LIM, 32'h0000_0000);
    wr(OFS_BCTL, 32'h0000_0340);
  endtask

  task automatic t_window;
    io(32'h0000_0000, 1'b0, 1'b0, 1'b0);
    io(32'h0000_0000, 1'b1, 1'b0, 1'b1);
    wr(OFS_IO1_BASE, 32'h0001_1000);
    wr(OFS_IO1_LIM, 32'h0000_10FD);
    rd(OFS_IO1_LIM, 32'h0000_10FC);
    io(32'h0001_10FF, 1'b0, 1'b1, 1'b0);
    io(32'h0001_1000, 1'b0, 1'b1, 1'b0);
    io(32'h0001_1100, 1'b0, 1'b0, 1'b0);
    io(32'h0001_0FFC, 1'b0, 1'b0, 1'b0);
    io(32'h0002_1000, 1'b0, 1'b0, 1'b0);
    io(32'h0001_1100, 1'b1, 1'b0, 1'b1);
    io(32'h0001_1004, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic t_isa;
    wr(OFS_IO0_LIM, 32'h0000_FFFF);
    wr(OFS_BCTL, 32'h0000_0004);
    io(32'h0000_0100, 1'b0, 1'b0, 1'b0);
    io(32'h0000_03C0, 1'b0, 1'b0, 1'b0);
    io(32'h0000_0400, 1'b0, 1'b1, 1'b0);
    wr(OFS_BCTL, 32'h0000_000C);
    io(32'h0000_03C0, 1'b0, 1'b1, 1'b0);
    io(32'h0000_03B0, 1'b0, 1'b1, 1'b0);
    io(32'h0000_03BC, 1'b0, 1'b0, 1'b0);
    wr(OFS_BCTL, 32'h0000_0000);
    io(32'h0000_0100, 1'b0, 1'b1, 1'b0);
  endtask

  task automatic t_ctrl;
    wr(OFS_BCTL, 32'h0000_0780);
    @(negedge clk);
    chk("ctrl set", 5'h1F, {posting, pref1, pref0, route, card_rst_n});
    @(posedge clk);
    wr(OFS_BCTL, 32'h0000_0040);
    @(negedge clk);
    chk("ctrl clr", 5'h00, {posting, pref1, pref0, route, card_rst_n});
    @(posedge clk);
    wr(OFS_BCTL, 32'h0000_0000);
    srst <= 1'b1;
    @(posedge clk);
    #1 chk("card_rst_n srst", 1'b0, card_rst_n);
    @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_abort;
    wr(OFS_BCTL, 32'h0000_0020);
    serr_enable <= 1'b1;
    abort(1'b1, 1'b1);
    serr_enable <= 1'b0;
    abort(1'b1, 1'b0);
    wr(OFS_BCTL, 32'h0000_0000);
    serr_enable <= 1'b1;
    abort(1'b0, 1'b0);
  endtask

  // count system error pulses while the card holds its error pin low
  task automatic serr_win(input logic [15:0] bc, output int cnt);
    wr(OFS_BCTL, {16'h0000, bc});
    serr_req <= 1'b1;
    cnt = 0;
    repeat (200) begin
      @(negedge clk);
      cnt += (serr_pulse === 1'b1);
    end
    @(posedge clk);
    serr_req <= 1'b0;
    repeat (60) @(posedge clk);
  endtask

  task automatic t_cserr;
    serr_enable <= 1'b0;
    serr_win(16'h0002, n);
    chk("cserr fwd", 1'b1, n != 0);
    serr_win(16'h0000, n);
    chk("cserr off", 0, n);
  endtask

  task automatic t_parity;
    wr(OFS_BCTL, 32'h0000_0001);
    card_parity_err <= 1'b1;
    @(posedge clk);
    card_parity_err <= 1'b0;
    #1 chk("perr drive", 3'b100, {cperr_oe, cperr_n_o, cperr_n_i});
    n = 0;
    while (cperr_oe !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("perr release", 2'b01, {cperr_oe, cperr_n_i});
    @(posedge clk);
    wr(OFS_BCTL, 32'h0000_0000);
    card_parity_err <= 1'b1;
    @(posedge clk);
    card_parity_err <= 1'b0;
    #1 chk("perr off", 1'b0, cperr_oe);
    @(posedge clk);
  endtask

  task automatic t_mode;
    wr(OFS_DEV_CTL, 32'h0000_0000);
    rd(OFS_IRQ_PIN, 32'h0000_0000);
    chk("irq_sel", 2'h0, irq_sel);
    wr(OFS_DEV_CTL, 32'h0000_0002);
    rd(OFS_IRQ_PIN, 32'h0000_0001);
    rd(OFS_DEV_CTL, 32'h0000_0002);
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {cfg_wr, cfg_rd, io_req, io_from_card, serr_req} = '0;
    {card_master_abort, card_parity_err, serr_enable} = '0;
    cfg_addr = '0;
    cfg_wdata = '0;
    io_addr = '0;
    error_cnt = 0;
    compares = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_masks();
    t_window();
    t_isa();
    t_ctrl();
    t_abort();
    t_cserr();
    t_parity();
    t_mode();
    stop_test();
  end
endmodule
